// file: src/boost_protection_clock_control.v
// Supervisory, protection and switching-clock logic of a peak-current-mode boost converter.
// Assumes comparator results and the shared enable/sync pin arrive asynchronously; all pass two flops.
// How it works
// - Latch mode once; spread for 370mV, >1V
// - Dither internal clock while spread enabled
// - Sync clock present disables spread spectrum
// - Slow triangle plus modulated fast triangle
// - Forced-off point tracks period, capping on-time
// - Align to sync falls outside forced off
// - Grounded pin stops switching, shutdown 35us
// - Switching follows sync, else internal oscillator
// - Current limit turns switch off immediately
// - Limit compare uses raw sensed current
// - Power good released only when feedback, supply and pin OK
// - Power good has 25us deglitch
// - Hiccup enabled for 370mV or 620mV
// - 64 limited cycles trip hiccup, pull soft-start
// - Hold off 32768 cycles then soft start
// - Eight clean cycles clear fault counter
// - Fault counter counts during soft-start too
// - Overvoltage stops switching, limits amplifier 60uA
// - Thermal trip kills regulator, restarts after cooling
// - Feedback grounded disables compensation minimum clamp
`timescale 1ns/1ns
`include "boost_ctl_consts.vh"
module boost_protection_clock_control (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire [1:0] mode_level_i,
  input wire enable_lockout_clock_pin_i,
  input wire pin_above_uvlo_i,
  input wire current_limit_i,
  input wire pwm_compare_i,
  input wire feedback_above_undervoltage_i,
  input wire feedback_above_overvoltage_i,
  input wire feedback_grounded_i,
  input wire supply_above_lockout_i,
  input wire thermal_trip_i,
  output reg switch_drive_o,
  output reg soft_start_pulldown_o,
  output reg regulator_enable_o,
  output reg amp_current_limited_o,
  output reg comp_min_clamp_enable_o,
  output reg power_good_output_o,
  output reg power_good_oe_n_o,
  output reg shutdown_o,
  output reg spread_active_o,
  output reg sync_locked_o,
  output reg hiccup_enable_o
);
  localparam ST_RUN = 3'h1;
  localparam ST_HICCUP = 3'h2;
  localparam ST_THERMAL = 3'h4;
  reg [1:0] mode_s1_r, mode_s2_r;
  reg [7:0] in_s1_r, in_s2_r;
  reg pin_d_r;
  wire pin_s = in_s2_r[0];
  wire uvlo_ok = in_s2_r[1];
  wire ilim = in_s2_r[2];
  wire pwm_trip = in_s2_r[3];
  wire fb_uv = in_s2_r[4];
  wire fb_ov = in_s2_r[5];
  wire fb_gnd = in_s2_r[6];
  wire vcc_ok = in_s2_r[7];
  reg therm_s1_r, therm_s2_r;
  reg mode_taken_r, spread_en_r, hiccup_en_r;
  reg [1:0] mode_wait_r;
  reg [2:0] state_r;
  reg [7:0] phase_r;
  reg [7:0] period_r;
  reg [15:0] sync_age_r;
  reg sync_r;
  reg [7:0] slow_div_r;
  reg [4:0] slow_tri_r;
  reg slow_up_r;
  reg [2:0] fast_tri_r;
  reg fast_up_r;
  reg [2:0] fast_amp_r;
  reg [15:0] low_cnt_r;
  reg [15:0] pg_cnt_r;
  reg [6:0] fault_cnt_r;
  reg [3:0] clean_cnt_r;
  reg [15:0] off_cnt_r;
  reg cycle_limited_r;
  reg on_r;
  wire pin_fall = pin_d_r & ~pin_s;
  // Forced off tracks the dithered period, so the on-time ceiling moves with it
  wire forced_off = phase_r >= (period_r - `OFF_FORCED);
  wire sync_edge = pin_fall & ~forced_off;
  wire dither = spread_en_r & ~sync_r;
  wire [7:0] dith_period = `PERIOD_NOM + {3'h0, slow_tri_r} + {5'h00, fast_tri_r} - 8'h08;
  wire cycle_end = sync_r ? sync_edge : (phase_r >= period_r - 8'h01);
  wire pin_low = ~pin_s;
  // While synced, a low shorter than a nominal period is a sync pulse, not a disable
  // Limitation: grounding the pin while synced stops switching up to one period late
  wire sync_low = sync_r & (low_cnt_r < {8'h00, `PERIOD_NOM});
  wire pin_up = pin_s | sync_low;
  wire uvlo_up = uvlo_ok | sync_low;
  wire can_switch = (state_r == ST_RUN) & pin_up & uvlo_up & vcc_ok & ~fb_ov;
  wire pg_ok = fb_uv & vcc_ok & pin_up;
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_s1_r <= 2'h0;
      mode_s2_r <= 2'h0;
      in_s1_r <= 8'h00;
      in_s2_r <= 8'h00;
      therm_s1_r <= 1'b0;
      therm_s2_r <= 1'b0;
      pin_d_r <= 1'b0;
    end else begin
      mode_s1_r <= mode_level_i;
      mode_s2_r <= mode_s1_r;
      in_s1_r <= {supply_above_lockout_i, feedback_grounded_i, feedback_above_overvoltage_i,
                  feedback_above_undervoltage_i, pwm_compare_i, current_limit_i, pin_above_uvlo_i,
                  enable_lockout_clock_pin_i};
      in_s2_r <= in_s1_r;
      therm_s1_r <= thermal_trip_i;
      therm_s2_r <= therm_s1_r;
      pin_d_r <= in_s2_r[0];
    end
  end
  // Mode is caught once, after the synchroniser has filled, never re-read, so later pin noise cannot flip it
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_wait_r <= 2'h0;
      mode_taken_r <= 1'b0;
      spread_en_r <= 1'b0;
      hiccup_en_r <= 1'b0;
    end else if (!mode_taken_r) begin
      if (mode_wait_r != 2'h2) begin
        mode_wait_r <= mode_wait_r + 2'h1;
      end else begin
        mode_taken_r <= 1'b1;
        spread_en_r <= (mode_s2_r == `MODE_370MV) | (mode_s2_r == `MODE_ABOVE_1V);
        hiccup_en_r <= (mode_s2_r == `MODE_370MV) | (mode_s2_r == `MODE_620MV);
      end
    end
  end
  // Sync detect and fallback
  // A stopped pulse train only ages out, so switching stalls at most SYNC_LOST_CYC cycles waiting for an edge
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_age_r <= 16'h0000;
      sync_r <= 1'b0;
    end else if (pin_fall) begin
      sync_age_r <= 16'h0000;
      sync_r <= 1'b1;
    end else if (sync_age_r >= `SYNC_LOST_CYC) begin
      sync_r <= 1'b0;
    end else begin
      sync_age_r <= sync_age_r + 16'h0001;
    end
  end
  // Dither modulator
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slow_div_r <= 8'h00;
      slow_tri_r <= 5'h00;
      slow_up_r <= 1'b1;
      fast_tri_r <= 3'h0;
      fast_up_r <= 1'b1;
      fast_amp_r <= 3'h1;
    end else if (dither && cycle_end) begin
      // Turn at both ends so the triangle never wraps below zero
      if (fast_up_r) begin
        fast_tri_r <= fast_tri_r + 3'h1;
        if (fast_tri_r + 3'h1 >= fast_amp_r)
          fast_up_r <= 1'b0;
      end else begin
        fast_tri_r <= fast_tri_r - 3'h1;
        if (fast_tri_r == 3'h1)
          fast_up_r <= 1'b1;
      end
      slow_div_r <= slow_div_r + 8'h01;
      if (slow_div_r == `SLOW_STEP_DIV) begin
        slow_div_r <= 8'h00;
        slow_up_r <= (slow_tri_r >= `SLOW_AMP + `SLOW_AMP - 5'h01) ? 1'b0 : (slow_tri_r == 5'h01 ? 1'b1 : slow_up_r);
        slow_tri_r <= slow_up_r ? slow_tri_r + 5'h01 : slow_tri_r - 5'h01;
        // Fast amplitude wanders so its repetition rate is not a fixed audible tone
        fast_amp_r <= (fast_amp_r == 3'h7) ? 3'h2 : fast_amp_r + 3'h1;
      end
    end
  end
  // Oscillator and switch
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_r <= 8'h00;
      period_r <= `PERIOD_NOM;
      on_r <= 1'b0;
      cycle_limited_r <= 1'b0;
    end else if (cycle_end) begin
      phase_r <= 8'h00;
      period_r <= dither ? dith_period : `PERIOD_NOM;
      on_r <= can_switch;
      cycle_limited_r <= 1'b0;
    end else begin
      if (phase_r != 8'hff)
        phase_r <= phase_r + 8'h01;
      // Comparator terminates the pulse; only the forced-off ceiling follows the dithered period
      if (ilim) begin
        on_r <= 1'b0;
        cycle_limited_r <= on_r | cycle_limited_r;
      end else if (pwm_trip || forced_off || !can_switch) begin
        on_r <= 1'b0;
      end
    end
  end
  // Hiccup, thermal and shutdown
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= ST_RUN;
      fault_cnt_r <= 7'h00;
      clean_cnt_r <= 4'h0;
      off_cnt_r <= 16'h0000;
      low_cnt_r <= 16'h0000;
    end else begin
      if (pin_low && low_cnt_r != `SHUTDOWN_CYC)
        low_cnt_r <= low_cnt_r + 16'h0001;
      else if (!pin_low)
        low_cnt_r <= 16'h0000;
      case (state_r)
        ST_RUN: begin
          if (therm_s2_r) begin
            state_r <= ST_THERMAL;
          // Counts through soft start too, so a hard start-up can trip
          end else if (hiccup_en_r && cycle_end) begin
            if (cycle_limited_r) begin
              clean_cnt_r <= 4'h0;
              if (fault_cnt_r == `HICCUP_TRIP - 7'h01) begin
                state_r <= ST_HICCUP;
                fault_cnt_r <= 7'h00;
                off_cnt_r <= 16'h0000;
              end else
                fault_cnt_r <= fault_cnt_r + 7'h01;
            end else if (clean_cnt_r == `HICCUP_CLEAN - 4'h1) begin
              clean_cnt_r <= 4'h0;
              fault_cnt_r <= 7'h00;
            end else
              clean_cnt_r <= clean_cnt_r + 4'h1;
          end
        end
        ST_HICCUP: begin
          if (therm_s2_r)
            state_r <= ST_THERMAL;
          else if (cycle_end) begin
            if (off_cnt_r == `HICCUP_OFF - 16'h0001)
              state_r <= ST_RUN;
            else
              off_cnt_r <= off_cnt_r + 16'h0001;
          end
        end
        ST_THERMAL: begin
          // Comparator itself carries the 15 C hysteresis
          if (!therm_s2_r)
            state_r <= ST_RUN;
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end
  // Power good deglitch: fault must persist before pull-down
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // Start pulled low until the monitors have been seen good
      pg_cnt_r <= `PG_DEGLITCH_CYC;
    end else if (pg_ok) begin
      pg_cnt_r <= 16'h0000;
    end else if (pg_cnt_r != `PG_DEGLITCH_CYC) begin
      pg_cnt_r <= pg_cnt_r + 16'h0001;
    end
  end
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      switch_drive_o <= 1'b0;
      soft_start_pulldown_o <= 1'b1;
      regulator_enable_o <= 1'b0;
      amp_current_limited_o <= 1'b0;
      comp_min_clamp_enable_o <= 1'b1;
      power_good_output_o <= 1'b0;
      power_good_oe_n_o <= 1'b0;
      shutdown_o <= 1'b0;
      spread_active_o <= 1'b0;
      sync_locked_o <= 1'b0;
      hiccup_enable_o <= 1'b0;
    end else begin
      switch_drive_o <= on_r & can_switch & ~ilim;
      soft_start_pulldown_o <= (state_r != ST_RUN) | ~vcc_ok | ~uvlo_up;
      regulator_enable_o <= (state_r != ST_THERMAL) & (low_cnt_r != `SHUTDOWN_CYC);
      amp_current_limited_o <= fb_ov;
      comp_min_clamp_enable_o <= ~fb_gnd;
      power_good_output_o <= 1'b0;
      power_good_oe_n_o <= (pg_cnt_r == `PG_DEGLITCH_CYC) ? 1'b0 : 1'b1;
      shutdown_o <= (low_cnt_r == `SHUTDOWN_CYC);
      spread_active_o <= dither;
      sync_locked_o <= sync_r;
      hiccup_enable_o <= hiccup_en_r;
    end
  end
endmodule

// file: src/boost_ctl_consts.vh
// Constants for the boost converter supervisory and clocking logic.
// Assumes a 25 MHz system clock; times are converted to cycle counts here.
`ifndef BOOST_CTL_CONSTS_VH
`define BOOST_CTL_CONSTS_VH
`define CLK_MHZ 16'h0019
// Mode setting codes from the mode-level comparator bank
`define MODE_W 2
`define MODE_LOW 2'h0
`define MODE_370MV 2'h1
`define MODE_620MV 2'h2
`define MODE_ABOVE_1V 2'h3
// Times in their own unit, then cycles
`define SHUTDOWN_US 16'h0023
`define SHUTDOWN_CYC (`SHUTDOWN_US * `CLK_MHZ)
`define PG_DEGLITCH_US 16'h0019
`define PG_DEGLITCH_CYC (`PG_DEGLITCH_US * `CLK_MHZ)
`define SYNC_LOST_CYC 16'h0400
// Hiccup counts
`define HICCUP_TRIP 7'h40
`define HICCUP_CLEAN 4'h8
`define HICCUP_OFF 16'h8000
// Oscillator: period in system cycles, max duty forced off-time
`define PERIOD_W 8
`define PERIOD_NOM 8'h40
`define OFF_FORCED 8'h04
// Dither
`define SLOW_STEP_DIV 8'h40
`define SLOW_AMP 5'h08
`define FAST_AMP 3'h4
`endif

// file: testbench/boost_ctl_asserts.sv
// Port checker for the boost supervisory and clocking block.
// Assumes the 25 MHz clock and active-low asynchronous reset.
`timescale 1ns/1ns
module boost_ctl_asserts (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire current_limit_i,
  input wire enable_lockout_clock_pin_i,
  input wire feedback_above_undervoltage_i,
  input wire feedback_above_overvoltage_i,
  input wire feedback_grounded_i,
  input wire supply_above_lockout_i,
  input wire thermal_trip_i,
  input wire switch_drive_o,
  input wire soft_start_pulldown_o,
  input wire regulator_enable_o,
  input wire amp_current_limited_o,
  input wire comp_min_clamp_enable_o,
  input wire power_good_oe_n_o,
  input wire shutdown_o,
  input wire spread_active_o,
  input wire sync_locked_o
);
  logic [9:0] low_r, bad_r;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // Saturating, so long lows never wrap
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_r <= 10'h0;
      bad_r <= 10'h0;
    end else begin
      low_r <= enable_lockout_clock_pin_i ? 10'h0 : low_r + {9'h0, low_r != 10'h3ff};
      bad_r <= feedback_above_undervoltage_i ? 10'h0 : bad_r + {9'h0, bad_r != 10'h3ff};
    end
  end
  property p_ilim; $rose(current_limit_i) |-> ##[0:4] !switch_drive_o; endproperty
  a_ilim: assert property (p_ilim) else $error("switch on after limit");
  property p_ovp; feedback_above_overvoltage_i [*5] |-> amp_current_limited_o && !switch_drive_o; endproperty
  a_ovp: assert property (p_ovp) else $error("overvoltage response missing");
  property p_hot; thermal_trip_i [*5] |-> !regulator_enable_o && soft_start_pulldown_o && !switch_drive_o;
  endproperty
  a_hot: assert property (p_hot) else $error("thermal response missing");
  property p_clamp; feedback_grounded_i [*5] |-> !comp_min_clamp_enable_o; endproperty
  a_clamp: assert property (p_clamp) else $error("clamp still on");
  property p_pin; !enable_lockout_clock_pin_i [*6] |-> !switch_drive_o; endproperty
  a_pin: assert property (p_pin) else $error("switching with pin low");
  property p_shut; low_r > 10'h375 |-> shutdown_o; endproperty
  a_shut: assert property (p_shut) else $error("shutdown late");
  property p_shut_early; $rose(shutdown_o) |-> low_r > 10'h364; endproperty
  a_shut_early: assert property (p_shut_early) else $error("shutdown early");
  property p_pgrel; $rose(power_good_oe_n_o) |-> $past(feedback_above_undervoltage_i, 3) &&
    $past(supply_above_lockout_i, 3); endproperty
  a_pgrel: assert property (p_pgrel) else $error("power good released early");
  property p_pgdg; $fell(feedback_above_undervoltage_i) && power_good_oe_n_o |-> power_good_oe_n_o [*8];
  endproperty
  a_pgdg: assert property (p_pgdg) else $error("power good glitched");
  property p_pgdn; bad_r > 10'h27a |-> !power_good_oe_n_o; endproperty
  a_pgdn: assert property (p_pgdn) else $error("power good not pulled");
  property p_spread; sync_locked_o [*3] |-> !spread_active_o; endproperty
  a_spread: assert property (p_spread) else $error("dither with sync");
  c_trip: cover property ($rose(soft_start_pulldown_o));
  c_lock: cover property ($rose(sync_locked_o));
  c_shut: cover property ($rose(shutdown_o));
endmodule
bind boost_protection_clock_control boost_ctl_asserts i_boost_ctl_asserts (.clk_sys_i, .resetn_i,
  .current_limit_i, .enable_lockout_clock_pin_i, .feedback_above_undervoltage_i,
  .feedback_above_overvoltage_i, .feedback_grounded_i, .supply_above_lockout_i, .thermal_trip_i,
  .switch_drive_o, .soft_start_pulldown_o, .regulator_enable_o, .amp_current_limited_o,
  .comp_min_clamp_enable_o, .power_good_oe_n_o, .shutdown_o, .spread_active_o, .sync_locked_o);

// file: testbench/stage_model.sv
// Power stage comparator and sync clock source model.
// Assumes the bench commands sync, grounding and overload.
`timescale 1ns/1ns
module stage_model (
  input wire clk_sys_i,
  input wire sync_on_i,
  input wire ground_i,
  input wire overload_i,
  input wire switch_drive_i,
  output logic pin_o,
  output logic ilim_o
);
  int cnt = 0;
  initial begin
    pin_o = 1'b1;
    ilim_o = 1'b0;
  end
  always @(posedge clk_sys_i) begin
    cnt <= (cnt == 59) ? 0 : cnt + 1;
    pin_o <= #1 !ground_i && !(sync_on_i && cnt < 5);
    ilim_o <= #1 overload_i && switch_drive_i;
  end
endmodule

// file: testbench/test_boost_protection_clock_control.sv
// Self-checking bench of the boost supervisory and clocking block.
// Assumes the stage model drives the shared pin and the limit comparator.
`timescale 1ns/1ns
module test_boost_protection_clock_control;
  logic clk_sys_i = 1'b0, resetn_i = 1'b0, sync_on = 1'b0, ground = 1'b0, overload = 1'b0, late = 1'b0;
  logic fb_uv = 1'b1, fb_ov = 1'b0, fb_gnd = 1'b0, hot = 1'b0, e;
  logic [1:0] mode = 2'h0;
  logic [3:0] k;
  logic [31:0] seed = 32'h12;
  int errors = 0, compares = 0, n;
  logic [3:0] kq[$];
  logic vq[$];
  event look;
  wire pin, ilim, sw, ss, reg_en, amp, clamp, pg, pg_oe_n, shut, spread, locked, hic;
  wire [11:0] outs = {pg, clamp, amp, late, reg_en, locked, ss, shut, sw, pg_oe_n, hic, spread};
  boost_protection_clock_control i_boost_protection_clock_control (.clk_sys_i, .resetn_i,
    .mode_level_i(mode), .enable_lockout_clock_pin_i(pin), .pin_above_uvlo_i(pin), .current_limit_i(ilim),
    .pwm_compare_i(1'b0), .feedback_above_undervoltage_i(fb_uv), .feedback_above_overvoltage_i(fb_ov),
    .feedback_grounded_i(fb_gnd), .supply_above_lockout_i(1'b1), .thermal_trip_i(hot), .switch_drive_o(sw),
    .soft_start_pulldown_o(ss), .regulator_enable_o(reg_en), .amp_current_limited_o(amp),
    .comp_min_clamp_enable_o(clamp), .power_good_output_o(pg), .power_good_oe_n_o(pg_oe_n),
    .shutdown_o(shut), .spread_active_o(spread), .sync_locked_o(locked), .hiccup_enable_o(hic));
  stage_model i_stage_model (.clk_sys_i, .sync_on_i(sync_on), .ground_i(ground), .overload_i(overload),
    .switch_drive_i(sw), .pin_o(pin), .ilim_o(ilim));
  initial forever #20 clk_sys_i = ~clk_sys_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic note(input logic [3:0] kk, input logic v);
    kq.push_back(kk);
    vq.push_back(v);
    -> look;
  endtask
  task automatic rst(input logic [1:0] m);
    mode = m;
    resetn_i = 1'b0;
    tick(8);
    resetn_i = 1'b1;
  endtask
  task automatic give_verdict();
    // Let the compare process drain notes made in this time step
    #1;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_for(input logic [3:0] kk, input logic v, input int lim);
    n = 0;
    while (outs[kk] !== v && n < lim) begin
      tick(1);
      n++;
    end
    if (outs[kk] !== v) begin
      errors++;
      give_verdict();
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Oldest note first, so order of expectations is kept
  always @(look) begin
    while (kq.size() > 0) begin
      k = kq.pop_front();
      e = vq.pop_front();
      cmp_bit(outs[k], e);
    end
  end
  initial begin
    for (int m = 0; m < 4; m++) begin
      rst(m[1:0]);
      // Change the mode only after it has been taken, to prove it is ignored
      tick(5);
      mode = ~mode;
      tick(15);
      note(0, m == 1 || m == 3);
      note(1, m == 1 || m == 2);
      note(2, 1'b1);
    end
    sync_on = 1'b1;
    tick(300);
    note(6, 1'b1);
    note(0, 1'b0);
    sync_on = 1'b0;
    tick(1300);
    note(6, 1'b0);
    note(0, 1'b1);
    repeat (3) begin
      seed = xs(seed);
      fb_uv = 1'b0;
      tick(1 + seed[8:0]);
      fb_uv = 1'b1;
      note(2, 1'b1);
      tick(10);
    end
    fb_uv = 1'b0;
    tick(640);
    note(2, 1'b0);
    fb_uv = 1'b1;
    tick(8);
    note(2, 1'b1);
    {hot, fb_ov, fb_gnd} = 3'h7;
    tick(8);
    note(5, 1'b1);
    note(7, 1'b0);
    note(3, 1'b0);
    note(9, 1'b1);
    note(10, 1'b0);
    note(11, 1'b0);
    {hot, fb_ov, fb_gnd} = 3'h0;
    tick(8);
    note(7, 1'b1);
    note(9, 1'b0);
    note(10, 1'b1);
    ground = 1'b1;
    tick(8);
    note(3, 1'b0);
    tick(890);
    note(4, 1'b1);
    ground = 1'b0;
    rst(2'h1);
    overload = 1'b1;
    tick(2560);
    overload = 1'b0;
    tick(1024);
    overload = 1'b1;
    tick(2560);
    note(5, 1'b0);
    wait_for(5, 1'b1, 6000);
    late = n > 32'h384;
    note(8, 1'b1);
    tick(200);
    note(3, 1'b0);
    give_verdict();
  end
endmodule
